/* File: verilog/panel_io_image.sv */
// Operator panel I/O image: input image, output image, driver protection
`include "panel_io_defines.svh"

module panel_io_image #(
   parameter int ROW_CYCLES = `MATRIX_ROW_CYCLES,
   parameter int ROWS = `MATRIX_ROWS
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire panel_io_pkg::out_write_t out_wr_i,
   input wire panel_io_pkg::in_read_req_t in_rd_i,
   input wire panel_io_pkg::supply_state_t supply_i,
   input wire logic [23:0] discrete_input_i,
   input wire logic [7:0] matrix_col_i,
   input wire logic [23:0] hand_pulse_generator_count_i,
   input wire logic [6:0] driver_fault_i,
   output logic [7:0] in_rd_data_o,
   output logic [ROWS-1:0] matrix_row_o,
   output logic [55:0] discrete_output_o,
   output logic [7:0] output_driver_alarm_o
);
   logic [7:0] out_image_q [0:`OUT_DRIVEN_BYTES-1];
   logic [7:0] in_image_d [0:`IN_IMAGE_BYTES-1];
   logic [ROWS*8-1:0] matrix_image;
   logic outputs_allowed;

   function automatic logic [7:0] gate_byte(input logic [7:0] cmd, input logic fault,
                                            input logic allowed);
      gate_byte = (fault || !allowed) ? 8'h00 : cmd;
   endfunction

   // ****************************************
   // Matrix scan
   // ****************************************
   matrix_scanner #(
      .ROWS(ROWS),
      .ROW_CYCLES(ROW_CYCLES)
   ) u_scan (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .matrix_col_i(matrix_col_i),
      .matrix_row_o(matrix_row_o),
      .matrix_image_o(matrix_image)
   );

   // ****************************************
   // Output image: host writes land here
   // ****************************************
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < `OUT_DRIVEN_BYTES; i++) begin
            out_image_q[i] <= `OUT_RESET_VALUE;
         end
      end else if (out_wr_i.valid && out_wr_i.offset != `OUT_RESERVED_OFS) begin
         out_image_q[out_wr_i.offset] <= out_wr_i.data;
      end
   end

   // Any supply or host fault drops every output, no latch needed
   assign outputs_allowed = !supply_i.system_alarm && supply_i.host_power_ok
                            && supply_i.module_power_ok && supply_i.output_common_supply;

   // ****************************************
   // Physical outputs with per-byte protection
   // ****************************************
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         discrete_output_o <= '0;
      end else begin
         for (int i = 0; i < `OUT_DRIVEN_BYTES; i++) begin
            // Fault only masks its own byte; the rest follow command
            discrete_output_o[i*8 +: 8] <=
               gate_byte(out_image_q[i], driver_fault_i[i], outputs_allowed);
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         output_driver_alarm_o <= `IN_RESET_VALUE;
      end else begin
         output_driver_alarm_o <= {1'b0, driver_fault_i};
      end
   end

   // ****************************************
   // Input image assembly
   // ****************************************
   always_comb begin
      for (int i = 0; i < `IN_IMAGE_BYTES; i++) begin
         in_image_d[i] = `IN_RESET_VALUE;
      end
      for (int i = 0; i < 3; i++) begin
         in_image_d[i] = discrete_input_i[i*8 +: 8];
      end
      for (int i = 0; i < ROWS; i++) begin
         in_image_d[4 + i] = matrix_image[i*8 +: 8];
      end
      in_image_d[`HANDWHEEL1_COUNT_OFS] = hand_pulse_generator_count_i[7:0];
      in_image_d[`HANDWHEEL2_COUNT_OFS] = hand_pulse_generator_count_i[15:8];
      in_image_d[`HANDWHEEL3_COUNT_OFS] = hand_pulse_generator_count_i[23:16];
      in_image_d[`OUTPUT_DRIVER_ALARM_OFS] = {1'b0, driver_fault_i};
   end

   // Reads return one cycle after the offset is presented
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         in_rd_data_o <= `IN_RESET_VALUE;
      end else begin
         in_rd_data_o <= in_image_d[in_rd_i.offset];
      end
   end
endmodule

/* File: verilog/panel_io_defines.svh */
// Constants for the panel I/O image block: offsets, field positions, reset values, timing
`ifndef PANEL_IO_DEFINES_SVH
`define PANEL_IO_DEFINES_SVH

// ********************************
// Image geometry
// ********************************
`define IN_IMAGE_BYTES 16
`define OUT_IMAGE_BYTES 8
`define OUT_DRIVEN_BYTES 7
`define IN_GENERAL_FIRST 4'h0
`define IN_GENERAL_LAST 4'h2
`define IN_MATRIX_FIRST 4'h4
`define IN_MATRIX_LAST 4'hA
`define HANDWHEEL1_COUNT_OFS 4'hC
`define HANDWHEEL2_COUNT_OFS 4'hD
`define HANDWHEEL3_COUNT_OFS 4'hE
`define OUTPUT_DRIVER_ALARM_OFS 4'hF
`define OUT_RESERVED_OFS 3'h7
`define ALARM_RESERVED_BIT 7
`define OUT_RESET_VALUE 8'h00
`define IN_RESET_VALUE 8'h00

// ********************************
// Matrix scan timing
// ********************************
`define CLK_PERIOD_NS 10
`define MATRIX_PERIOD_MAX_MS 16
`define MATRIX_ROWS 7
`define MATRIX_PERIOD_CYCLES ((`MATRIX_PERIOD_MAX_MS * 1000000) / `CLK_PERIOD_NS)
`define MATRIX_ROW_CYCLES (`MATRIX_PERIOD_CYCLES / `MATRIX_ROWS)

`endif

/* File: verilog/panel_io_pkg.sv */
// Types shared by the panel I/O image block
package panel_io_pkg;
   typedef struct packed {
      logic [3:0] offset;
   } in_read_req_t;

   typedef struct packed {
      logic       valid;
      logic [2:0] offset;
      logic [7:0] data;
   } out_write_t;

   typedef struct packed {
      logic system_alarm;
      logic host_power_ok;
      logic module_power_ok;
      logic output_common_supply;
   } supply_state_t;

   typedef enum logic [2:0] {
      SCAN_IDLE = 3'b001,
      SCAN_SETTLE = 3'b010,
      SCAN_SAMPLE = 3'b100
   } scan_state_t;
endpackage

/* File: verilog/matrix_scanner.sv */
// Matrix input scanner: walks the rows and latches each row's columns
`include "panel_io_defines.svh"

module matrix_scanner #(
   parameter int ROWS = `MATRIX_ROWS,
   parameter int ROW_CYCLES = `MATRIX_ROW_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] matrix_col_i,
   output logic [ROWS-1:0] matrix_row_o,
   output logic [ROWS*8-1:0] matrix_image_o
);
   localparam int CW = $clog2(ROW_CYCLES + 1);
   localparam int RW = $clog2(ROWS + 1);
   localparam logic [CW-1:0] ROW_LAST = CW'(ROW_CYCLES - 1);
   localparam logic [RW-1:0] ROW_MAX = RW'(ROWS - 1);

   panel_io_pkg::scan_state_t state_q;
   logic [CW-1:0] cnt_q;
   logic [RW-1:0] row_q;

   // ****************************************
   // Row timing: one full sweep within the period bound
   // ****************************************
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         state_q <= panel_io_pkg::SCAN_IDLE;
         cnt_q <= '0;
         row_q <= '0;
      end else begin
         case (state_q)
            panel_io_pkg::SCAN_IDLE: begin
               cnt_q <= '0;
               state_q <= panel_io_pkg::SCAN_SETTLE;
            end
            panel_io_pkg::SCAN_SETTLE: begin
               // Columns settle for most of the row slot before sampling
               if (cnt_q >= ROW_LAST - CW'(1)) begin
                  state_q <= panel_io_pkg::SCAN_SAMPLE;
               end
               cnt_q <= cnt_q + CW'(1);
            end
            panel_io_pkg::SCAN_SAMPLE: begin
               cnt_q <= '0;
               row_q <= (row_q == ROW_MAX) ? '0 : row_q + RW'(1);
               state_q <= panel_io_pkg::SCAN_SETTLE;
            end
            default: begin
               state_q <= panel_io_pkg::SCAN_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         matrix_row_o <= '0;
      end else begin
         matrix_row_o <= ROWS'(1) << row_q;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         matrix_image_o <= '0;
      end else if (state_q == panel_io_pkg::SCAN_SAMPLE) begin
         matrix_image_o[row_q*8 +: 8] <= matrix_col_i;
      end
   end
endmodule

/* File: tb/panel_io_image_properties.sv */
// Port assertions for the panel I/O image block
module panel_io_image_properties #(
   parameter int ROW_CYCLES = 8,
   parameter int ROWS = 7
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire panel_io_pkg::out_write_t out_wr_i,
   input wire panel_io_pkg::in_read_req_t in_rd_i,
   input wire panel_io_pkg::supply_state_t supply_i,
   input wire logic [23:0] discrete_input_i,
   input wire logic [7:0] matrix_col_i,
   input wire logic [23:0] hand_pulse_generator_count_i,
   input wire logic [6:0] driver_fault_i,
   input wire logic [7:0] in_rd_data_o,
   input wire logic [ROWS-1:0] matrix_row_o,
   input wire logic [55:0] discrete_output_o,
   input wire logic [7:0] output_driver_alarm_o
);
   logic ok;
   logic [55:0] fmask;
   always_comb begin
      ok = !supply_i.system_alarm && supply_i.host_power_ok;
      ok = ok && supply_i.module_power_ok && supply_i.output_common_supply;
      for (int k = 0; k < 7; k++)
         fmask[8*k +: 8] = {8{driver_fault_i[k]}};
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   a_alarm_off: assert property (
      supply_i.system_alarm |=> discrete_output_o == 56'h0) else $error("output on in alarm");
   a_power_off: assert property (
      !(supply_i.host_power_ok && supply_i.module_power_ok) |=> discrete_output_o == 56'h0)
      else $error("output on without power");
   a_common_off: assert property (
      !supply_i.output_common_supply |=> discrete_output_o == 56'h0)
      else $error("output on without common supply");
   a_flag_follow: assert property (
      !sys_rst_i |=> output_driver_alarm_o == {1'b0, $past(driver_fault_i)})
      else $error("alarm byte wrong");
   a_fault_off: assert property (
      !sys_rst_i |=> (discrete_output_o & $past(fmask)) == 56'h0) else $error("faulted byte on");
   a_resv_zero: assert property (
      in_rd_i.offset inside {4'h3, 4'hB} |=> in_rd_data_o == 8'h00) else $error("reserved not 0");
   a_wheel_read: assert property (
      in_rd_i.offset == 4'hD |=> in_rd_data_o == $past(hand_pulse_generator_count_i[15:8]))
      else $error("handwheel byte wrong");
   a_write_lands: assert property (
      out_wr_i.valid && out_wr_i.offset == 3'h2 ##1 !out_wr_i.valid && ok && !driver_fault_i[2]
      |=> discrete_output_o[23:16] == $past(out_wr_i.data, 2)) else $error("write lost");
   a_row_single: assert property (
      !sys_rst_i |=> $onehot0(matrix_row_o)) else $error("two rows driven");
   c_fault: cover property (driver_fault_i != 7'h00);
   c_resv_write: cover property (out_wr_i.valid && out_wr_i.offset == 3'h7);
   c_common_off: cover property (!supply_i.output_common_supply);
endmodule

/* File: tb/panel_keys_model.sv */
// Key matrix model: reports the pressed keys of the driven row
module panel_keys_model #(
   parameter int ROWS = 7
) (
   input wire logic [ROWS-1:0] matrix_row_i,
   input wire logic [8*ROWS-1:0] keys_i,
   output logic [7:0] matrix_col_o
);
   // Columns float high with no row driven, to expose mistimed sampling
   always_comb begin
      matrix_col_o = 8'hFF;
      for (int r = 0; r < ROWS; r++)
         if (matrix_row_i[r]) matrix_col_o = keys_i[8*r +: 8];
   end
endmodule

/* File: tb/panel_io_image_tb_top.sv */
// Self-checking bench for the panel I/O image block
module panel_io_image_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst;
   panel_io_pkg::out_write_t wr;
   panel_io_pkg::in_read_req_t rd;
   panel_io_pkg::supply_state_t sup;
   logic [23:0] di, hp;
   logic [6:0] flt, row;
   logic [55:0] keys, dout;
   logic [7:0] col, rdd, alm;
   logic [7:0] img [7];
   int err_total, n_compared;
   panel_io_image #(.ROW_CYCLES(8), .ROWS(7)) i_dut (.sys_clk_i(clk), .sys_rst_i(rst),
      .out_wr_i(wr), .in_rd_i(rd), .supply_i(sup), .discrete_input_i(di), .matrix_col_i(col),
      .hand_pulse_generator_count_i(hp), .driver_fault_i(flt), .in_rd_data_o(rdd),
      .matrix_row_o(row), .discrete_output_o(dout), .output_driver_alarm_o(alm));
   panel_keys_model #(.ROWS(7)) i_keys (.matrix_row_i(row), .keys_i(keys), .matrix_col_o(col));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input string what, input logic [55:0] seen, input logic [55:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim();
      if (err_total == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   function automatic logic [55:0] exp_out();
      logic [55:0] v;
      for (int k = 0; k < 7; k++)
         v[8*k +: 8] = flt[k] ? 8'h00 : img[k];
      if (sup !== 4'h7) v = 56'h0;
      return v;
   endfunction
   function automatic logic [7:0] exp_in(input int o);
      if (o < 3) return di[8*o +: 8];
      if (o >= 4 && o <= 10) return keys[8*(o-4) +: 8];
      if (o >= 12 && o <= 14) return hp[8*(o-12) +: 8];
      if (o == 15) return {1'b0, flt};
      return 8'h00;
   endfunction
   task automatic wr_byte(input logic [2:0] o, input logic [7:0] d);
      @(negedge clk);
      wr = '{1'b1, o, d};
      if (o != 3'h7) img[o] = d;
      @(negedge clk);
      wr.valid = 1'b0;
   endtask
   task automatic out_chk();
      @(negedge clk);
      check("outputs", dout, exp_out());
      check("alarm byte", {48'h0, alm}, {48'h0, 1'b0, flt});
   endtask
   task automatic rd_chk(input int o);
      @(negedge clk);
      rd.offset = 4'(o);
      @(negedge clk);
      check("input byte", {48'h0, rdd}, {48'h0, exp_in(o)});
   endtask
   initial begin
      void'($urandom(33476));
      rst = 1'b1;
      wr = '0;
      rd = '0;
      sup = 4'h7;
      flt = 7'h00;
      di = 24'($urandom());
      hp = 24'($urandom());
      keys = 56'({$urandom(), $urandom()});
      foreach (img[k]) img[k] = 8'h00;
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      for (int k = 0; k < 8; k++) begin
         wr_byte(3'(k), 8'($urandom()));
         out_chk();
      end
      // Paired outputs share one byte so they switch in the same write
      wr_byte(3'h0, 8'h03);
      out_chk();
      wr_byte(3'h0, 8'h00);
      out_chk();
      flt = 7'($urandom()) | 7'h04;
      out_chk();
      rd_chk(15);
      wr_byte(3'h2, 8'h5A);
      out_chk();
      flt = 7'h00;
      out_chk();
      rd_chk(15);
      for (int b = 0; b < 4; b++) begin
         sup = 4'h7 ^ (4'h1 << b);
         out_chk();
         sup = 4'h7;
         out_chk();
      end
      repeat (130) @(negedge clk);
      for (int o = 0; o < 16; o++) rd_chk(o);
      end_sim();
   end
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      end_sim();
   end
endmodule
bind panel_io_image panel_io_image_properties #(.ROW_CYCLES(ROW_CYCLES), .ROWS(ROWS)) i_props (
   .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .out_wr_i(out_wr_i), .in_rd_i(in_rd_i),
   .supply_i(supply_i), .discrete_input_i(discrete_input_i), .matrix_col_i(matrix_col_i),
   .hand_pulse_generator_count_i(hand_pulse_generator_count_i), .driver_fault_i(driver_fault_i),
   .in_rd_data_o(in_rd_data_o), .matrix_row_o(matrix_row_o),
   .discrete_output_o(discrete_output_o), .output_driver_alarm_o(output_driver_alarm_o));
